/* File: hdl/pst_pkg.sv */
// Purpose: Shared constants and types for the protection stage pick-up timer
// Assumes: 100 MHz clock; one program cycle equals one 0.005 s delay step
// Notes:   Curve constants are a linear stand-in for the inverse-time curves
`default_nettype none
package pst_pkg;

    // Clock and program cycle timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int CYCLE_TIME_US = 5000;
    localparam int CYCLE_CLKS    = (CLK_HZ / 1_000_000) * CYCLE_TIME_US;
    localparam int CYCLE_CNT_W   = 20;

    // Data widths
    localparam int MEAS_W  = 16;
    localparam int DLY_W   = 19;
    localparam int K_W     = 12;
    localparam int ACC_W   = 32;
    localparam int STAMP_W = 32;
    localparam int FAULT_W = 2;
    localparam int PCT_W   = 24;

    // Delay setting in 0.005 s steps: 0.040 s by default
    localparam int                DLY_STEP_US = 5000;
    localparam int                DLY_DEF_US  = 40000;
    localparam logic [DLY_W-1:0]  DLY_DEFAULT = DLY_W'(DLY_DEF_US / DLY_STEP_US);
    localparam logic [DLY_W-1:0]  DLY_ZERO    = 19'h00000;
    localparam logic [DLY_W-1:0]  DLY_MAX     = 19'h7FFFF;

    // Pick-up and reset ratios in percent of the setting
    localparam logic [PCT_W-1:0] PICK_PCT        = 24'h000064;
    localparam logic [PCT_W-1:0] RESET_PCT       = 24'h000061;
    localparam logic [PCT_W-1:0] UNDER_RESET_PCT = 24'h000067;

    // Inverse-time scale per curve series, multiplied by the time dial
    localparam logic [ACC_W-1:0] IEC_CONST  = 32'h00000200;
    localparam logic [ACC_W-1:0] IEEE_CONST = 32'h00000100;
    localparam logic [ACC_W-1:0] ACC_ZERO   = 32'h00000000;
    localparam logic [ACC_W-1:0] ACC_MAX    = 32'hFFFFFFFF;
    localparam logic [STAMP_W-1:0] STAMP_ONE = 32'h00000001;

    typedef enum logic [0:0] {
        fixed_delay_mode  = 1'b0,
        inverse_time_mode = 1'b1
    } pst_delay_t;

    typedef enum logic [0:0] {
        series_iec  = 1'b0,
        series_ieee = 1'b1
    } pst_series_t;

    localparam pst_delay_t  DELAY_TYPE_DEFAULT = fixed_delay_mode;
    localparam pst_series_t SERIES_DEFAULT     = series_iec;

    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_timing  = 2'b01,
        st_tripped = 2'b10,
        st_blocked = 2'b11
    } pst_state_t;

endpackage : pst_pkg
`default_nettype wire

/* File: hdl/pst_if.sv */
// Purpose: Carrier between the stage core, its cycle ticker and its comparator
// Assumes: Single clock domain
// Notes:   No clocking block; plain modports
`timescale 1ns/1ps
`default_nettype none
interface pst_if;
    import pst_pkg::*;
    logic              tick;
    logic [MEAS_W-1:0] meas;
    logic [MEAS_W-1:0] pick_level;
    logic              under_stage;
    logic              picked;

    modport ticker     (output tick);
    modport comparator (input tick, input meas, input pick_level, input under_stage, output picked);
    modport core       (input tick, input picked, output meas, output pick_level, output under_stage);
endinterface : pst_if
`default_nettype wire

/* File: hdl/pst_cycle_tick.sv */
// Purpose: Program cycle enable divider
// Assumes: CLKS at least 2
// Notes:   One-cycle tick every CLKS clocks
`timescale 1ns/1ps
`default_nettype none
module pst_cycle_tick
    import pst_pkg::*;
#(
    parameter int CLKS = CYCLE_CLKS
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Tick out
    pst_if.ticker     tk
);

    logic [CYCLE_CNT_W-1:0] div;

    // Free-running divider; tick on wrap
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            div <= '0;
        else if (div == CYCLE_CNT_W'(CLKS - 1))
            div <= '0;
        else
            div <= div + 1'b1;
    end

    assign tk.tick = (div == CYCLE_CNT_W'(CLKS - 1));

endmodule : pst_cycle_tick
`default_nettype wire

/* File: hdl/pst_pickup.sv */
// Purpose: Pick-up comparator with reset hysteresis
// Assumes: Evaluated once per program cycle
// Notes:   Under stages release at 103 % to mirror the 3 % band
`timescale 1ns/1ps
`default_nettype none
module pst_pickup
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Comparator side
    pst_if.comparator cmp
);

    logic [PCT_W-1:0] meas_pct;
    logic [PCT_W-1:0] pick_pct;
    logic [PCT_W-1:0] rel_pct;
    logic [PCT_W-1:0] urel_pct;
    logic             picked;

    // Scaled products avoid a divider in the ratio test
    assign meas_pct = PCT_W'(cmp.meas) * PICK_PCT;
    assign pick_pct = PCT_W'(cmp.pick_level) * PICK_PCT;
    assign rel_pct  = PCT_W'(cmp.pick_level) * RESET_PCT;
    assign urel_pct = PCT_W'(cmp.pick_level) * UNDER_RESET_PCT;

    // Pick-up and hysteretic release, once per cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            picked <= 1'b0;
        else if (cmp.tick)
        begin
            if (!cmp.under_stage)
                picked <= picked ? (meas_pct >= rel_pct) : (meas_pct > pick_pct);
            else
                picked <= picked ? (meas_pct <= urel_pct) : (meas_pct < pick_pct);
        end
    end

    assign cmp.picked = picked;

    AST_PICK_OVER: assert property (@(posedge clk) disable iff (!rst_n)
        cmp.tick && !cmp.under_stage && meas_pct > pick_pct |=> picked)
        else $error("over stage did not pick up");
    AST_HOLD_HYST: assert property (@(posedge clk) disable iff (!rst_n)
        cmp.tick && picked && !cmp.under_stage && meas_pct >= rel_pct |=> picked)
        else $error("pick-up released above reset ratio");

endmodule : pst_pickup
`default_nettype wire

/* File: hdl/pst_stage.sv */
// Purpose: Protection stage: pick-up, blocking and operating-time counter
// Assumes: Settings are static between pick-ups; inputs synchronous to clk
// Notes:   Inverse time integrates the excess over the setting each cycle
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Pick up when measurement passes the setting
// - Release only past 97 percent reset ratio, 103 percent for under stages
// - Sample blocking at each program cycle start
// - Unblocked pick-up raises start, begins timing
// - Blocked pick-up raises blocked, never times
// - Blocking during start clears start, releases timer
// - Blocking emits time-stamped event with values
// - Instant mode trips together with start
// - Fixed delay trips after delay, continuous pick-up
// - Inverse mode delay follows measurement excess over the setting
// - Inverse mode never trips before minimum delay
// - Delay type selects fixed or inverse counting
// - Fixed delay counts in 0.005 s steps
// - Zero fixed delay trips instantly
// - Curve series applies only in inverse mode
module pst_stage
    import pst_pkg::*;
#(
    parameter int CYCLE_CLKS_P = CYCLE_CLKS
)(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Settings
    input  wire pst_delay_t         delay_type,
    input  wire pst_series_t        curve_series,
    input  wire logic               under_stage,
    input  wire logic [MEAS_W-1:0]  pick_level,
    input  wire logic [DLY_W-1:0]   fixed_delay,
    input  wire logic [K_W-1:0]     time_dial,
    // Measurement and blocking
    input  wire logic [MEAS_W-1:0]  meas,
    input  wire logic               block_in,
    input  wire logic [FAULT_W-1:0] fault_type,
    // Stage flags
    output logic                    start,
    output logic                    blocked,
    output logic                    trip,
    // Blocking event
    output logic                    blk_event,
    output logic [STAMP_W-1:0]      blk_stamp,
    output logic [MEAS_W-1:0]       blk_value,
    output logic [FAULT_W-1:0]      blk_fault
);

    ////////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    pst_if pif ();

    assign pif.meas        = meas;
    assign pif.pick_level  = pick_level;
    assign pif.under_stage = under_stage;

    pst_cycle_tick #(
        .CLKS (CYCLE_CLKS_P)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tk    (pif.ticker)
    );

    pst_pickup u_pick (
        .clk   (clk),
        .rst_n (rst_n),
        .cmp   (pif.comparator)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decisions for this cycle

    pst_state_t         state;
    pst_state_t         next_state;
    logic               tick;
    logic               picked;
    logic               blk_smp;
    logic [DLY_W-1:0]   cnt;
    logic [DLY_W-1:0]   next_cnt;
    logic [ACC_W-1:0]   acc;
    logic [ACC_W-1:0]   next_acc;
    logic [ACC_W-1:0]   inv_target;
    logic [ACC_W-1:0]   series_const;
    logic [MEAS_W-1:0]  excess;
    logic [STAMP_W-1:0] stamp;
    logic [MEAS_W-1:0]  start_value;
    logic               time_up;
    logic               go_block;

    assign tick   = pif.tick;
    assign picked = pif.picked;

    // Blocking level seen at the cycle start, before any pick-up consequence
    assign blk_smp = block_in;

    // Series matters only for the inverse target
    assign series_const = (curve_series == series_ieee) ? IEEE_CONST : IEC_CONST;
    assign inv_target   = ACC_W'(time_dial) * series_const;

    // Distance past the setting drives the inverse integration
    always_comb
    begin
        excess = '0;
        if (!under_stage && meas > pick_level)
            excess = meas - pick_level;
        else if (under_stage && pick_level > meas)
            excess = pick_level - meas;
    end

    // Saturating cycle and excess counts
    assign next_cnt = (cnt == DLY_MAX) ? cnt : cnt + 1'b1;
    assign next_acc = (acc > ACC_MAX - ACC_W'(excess)) ? ACC_MAX : acc + ACC_W'(excess);

    // Expiry test; the minimum delay also bounds inverse tripping
    always_comb
    begin
        if (delay_type == fixed_delay_mode)
            time_up = (next_cnt >= fixed_delay);
        else
            time_up = (next_acc >= inv_target) && (next_cnt >= fixed_delay);
    end

    // Blocking takes effect on a pick-up while the sampled block is high
    assign go_block = picked && blk_smp && (state != st_blocked);

    ////////////////////////////////////////////////////////////////////////////
    // Stage state

    always_comb
    begin
        next_state = state;
        unique case (state)
            st_idle:
            begin
                if (picked && blk_smp)
                    next_state = st_blocked;
                else if (picked && delay_type == fixed_delay_mode && fixed_delay == DLY_ZERO)
                    next_state = st_tripped;
                else if (picked)
                    next_state = st_timing;
            end
            st_timing:
            begin
                if (!picked)
                    next_state = st_idle;
                else if (blk_smp)
                    next_state = st_blocked;
                else if (time_up)
                    next_state = st_tripped;
            end
            st_tripped:
            begin
                if (!picked)
                    next_state = st_idle;
                else if (blk_smp)
                    next_state = st_blocked;
            end
            st_blocked:
            begin
                if (!picked || !blk_smp)
                    next_state = st_idle;
            end
        endcase
    end

    // State only moves on the program cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= st_idle;
        else if (tick)
            state <= next_state;
    end

    // Operating-time counters restart from zero on every new start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            acc <= ACC_ZERO;
        end
        else if (tick)
        begin
            if (next_state == st_timing && state == st_timing)
            begin
                cnt <= next_cnt;
                acc <= next_acc;
            end
            else if (next_state == st_tripped && state == st_timing)
            begin
                cnt <= next_cnt;
                acc <= next_acc;
            end
            else if (next_state != st_tripped)
            begin
                cnt <= '0;
                acc <= ACC_ZERO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output flags

    // Flags are registered copies of the state, so trip never leads start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            start   <= 1'b0;
            trip    <= 1'b0;
            blocked <= 1'b0;
        end
        else if (tick)
        begin
            start   <= (next_state == st_timing) || (next_state == st_tripped);
            trip    <= (next_state == st_tripped);
            blocked <= (next_state == st_blocked);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Blocking event record

    // Cycle count used as the event time stamp
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stamp <= '0;
        else if (tick)
            stamp <= stamp + STAMP_ONE;
    end

    // Value held from the start; an immediate block records the present value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            start_value <= '0;
        else if (tick && state == st_idle && picked)
            start_value <= meas;
    end

    // One-clock event pulse with its record
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            blk_event <= 1'b0;
            blk_stamp <= '0;
            blk_value <= '0;
            blk_fault <= '0;
        end
        else
        begin
            blk_event <= tick && go_block;
            if (tick && go_block)
            begin
                blk_stamp <= stamp;
                blk_value <= (state == st_idle) ? meas : start_value;
                blk_fault <= fault_type;
            end
        end
    end

    // A block sampled on the expiry cycle still wins over the trip, since
    // blocking is tested before expiry when both are decided in the same cycle.

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_INSTANT: assert property (@(posedge clk) disable iff (!rst_n)
        tick && state == st_idle && picked && !block_in && delay_type == fixed_delay_mode
        && fixed_delay == DLY_ZERO |=> trip && start)
        else $error("instant trip missing");
    AST_BLOCKED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        blocked |-> !start && !trip)
        else $error("blocked stage is timing or tripping");
    AST_START_UNBLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(start) |-> !$past(block_in) && $past(picked))
        else $error("start raised without clean pick-up");
    AST_BLOCK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        tick && start && picked && block_in |=> !start && !trip && blocked && blk_event)
        else $error("blocking did not clear start");
    AST_EVENT_REC: assert property (@(posedge clk) disable iff (!rst_n)
        blk_event |-> blocked && blk_fault == $past(fault_type))
        else $error("blocking event record wrong");
    AST_FIXED_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(trip) && delay_type == fixed_delay_mode |-> fixed_delay == DLY_ZERO || cnt >= fixed_delay)
        else $error("fixed delay trip too early");
    AST_INV_MIN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(trip) && delay_type == inverse_time_mode |-> cnt >= fixed_delay && acc >= inv_target)
        else $error("inverse trip before minimum delay");
    AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !picked |=> !start && !trip && cnt == DLY_ZERO)
        else $error("release did not clear timer");
    AST_CYCLE_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
        !tick |=> $stable(start) && $stable(trip) && $stable(blocked))
        else $error("flags moved between program cycles");

    COV_FIXED_TRIP: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(trip) && delay_type == fixed_delay_mode && fixed_delay != DLY_ZERO);
    COV_INV_TRIP: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(trip) && delay_type == inverse_time_mode);
    COV_BLOCK_AT_PICK: cover property (@(posedge clk) disable iff (!rst_n)
        blk_event && !$past(start));
    COV_BLOCK_IN_START: cover property (@(posedge clk) disable iff (!rst_n)
        blk_event && $past(start));

endmodule : pst_stage
`default_nettype wire

/* File: testbench/pst_far_model.sv */
// Purpose: Far side model: measurement front end and blocking matrix
// Assumes: Targets come from the bench; one clock of transport delay
// Notes:   Outputs are always driven, so nothing is released or floats
`timescale 1ns/1ps
`default_nettype none
module pst_far_model
    import pst_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Wanted values from the bench
    input  wire logic [MEAS_W-1:0]  tgt_meas,
    input  wire logic               tgt_block,
    input  wire logic [FAULT_W-1:0] tgt_fault,
    // Towards the stage
    output logic [MEAS_W-1:0]       meas,
    output logic                    block_in,
    output logic [FAULT_W-1:0]      fault_type
);
    // Digitised magnitude lags the target by one clock, like a converter
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            meas <= 16'h0000;
        else
            meas <= tgt_meas;
    end

    // Blocking matrix; bench raises it whole cycles before expiry
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            block_in   <= 1'b0;
            fault_type <= 2'h0;
        end
        else
        begin
            block_in   <= tgt_block;
            fault_type <= tgt_fault;
        end
    end
endmodule : pst_far_model
`default_nettype wire

/* File: testbench/protection_stage_pickup_timer_tb.sv */
// Purpose: Self-checking bench for the protection stage
// Assumes: Eight clocks per program cycle; stimulus mid-cycle
// Notes:   Inverse timing judged by ordering, not by exact counts
`timescale 1ns/1ps
`default_nettype none
module protection_stage_pickup_timer_tb;
    import pst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic               clk, rst_n, under_stage, tgt_block;
    pst_delay_t         delay_type;
    pst_series_t        curve_series;
    logic [MEAS_W-1:0]  pick_level, tgt_meas, meas, blk_value;
    logic [DLY_W-1:0]   fixed_delay;
    logic [K_W-1:0]     time_dial;
    logic [FAULT_W-1:0] tgt_fault, fault_type, blk_fault;
    logic               block_in, start, blocked, trip, blk_event;
    logic [STAMP_W-1:0] blk_stamp;
    int                 errors = 0;
    int                 n_tests = 0;
    int                 n_evt = 0;
    int                 e0, na, nb, nc;
    logic [STAMP_W-1:0] s0;

    ////////////////////////////////////////////////////////////////////////////
    // Design and far side
    pst_stage #(.CYCLE_CLKS_P(8)) u_pst_stage (.clk(clk), .rst_n(rst_n), .delay_type(delay_type),
        .curve_series(curve_series), .under_stage(under_stage), .pick_level(pick_level),
        .fixed_delay(fixed_delay), .time_dial(time_dial), .meas(meas), .block_in(block_in),
        .fault_type(fault_type), .start(start), .blocked(blocked), .trip(trip),
        .blk_event(blk_event), .blk_stamp(blk_stamp), .blk_value(blk_value), .blk_fault(blk_fault));
    pst_far_model u_pst_far_model (.clk(clk), .rst_n(rst_n), .tgt_meas(tgt_meas), .tgt_block(tgt_block),
        .tgt_fault(tgt_fault), .meas(meas), .block_in(block_in), .fault_type(fault_type));

    // Clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Event pulses counted per clock, so a stretched pulse shows up
    always @(posedge clk)
        if (blk_event === 1'b1)
            n_evt <= n_evt + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task step(input int n);
        repeat (n * 8) @(posedge clk);
    endtask : step

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : check

    // Steps from applying a magnitude until trip, then back to idle
    task measure(input logic [MEAS_W-1:0] m, output int n);
        tgt_meas <= m;
        n = 0;
        while (trip !== 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        tgt_meas <= 16'h0000;
        step(3);
    endtask : measure

    task results;
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // Watchdog; the tests need well under 20 us
    initial
    begin
        #500000;
        errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Tests
    initial
    begin
        rst_n = 1'b0; delay_type = fixed_delay_mode; curve_series = series_iec; under_stage = 1'b0;
        pick_level = 16'h0064; fixed_delay = 19'h00002; time_dial = 12'h001;
        tgt_meas = 16'h0000; tgt_block = 1'b0; tgt_fault = 2'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk); // Now mid program cycle
        check("flags", 0, {start, blocked, trip, blk_event});
        // Equal to the setting is not a pick-up; one above is
        tgt_meas <= 16'h0064; step(2);
        check("start", 0, start);
        tgt_meas <= 16'h0065; step(2);
        check("start", 2, {start, trip});
        step(1);
        check("trip", 0, trip);
        step(1);
        check("trip", 1, trip);
        // Exactly 97 percent holds, below it releases
        tgt_meas <= 16'h0061; step(2);
        check("start", 3, {start, trip});
        tgt_meas <= 16'h0060; step(2);
        check("start", 0, {start, trip});
        // Zero delay trips with start
        fixed_delay <= 19'h00000; tgt_meas <= 16'h0065; step(1);
        check("start", 0, {start, trip});
        step(1);
        check("start", 3, {start, trip});
        tgt_meas <= 16'h0000; fixed_delay <= 19'h00002; step(3);
        // Blocked before pick-up
        tgt_block <= 1'b1; tgt_fault <= 2'h2; e0 = n_evt;
        tgt_meas <= 16'h0070; step(2);
        check("blocked", 2, {start, blocked, trip});
        step(4);
        check("blocked", 2, {start, blocked, trip});
        check("events", 1, n_evt - e0);
        check("blk_fault", 2, blk_fault);
        check("blk_value", 16'h0070, blk_value);
        check("blk_stamp", 32'h00000010, blk_stamp);
        s0 = blk_stamp;
        // Block drops while picked: fresh start
        tgt_block <= 1'b0; step(2);
        check("start", 4, {start, blocked, trip});
        // Block during start clears start, no trip follows
        tgt_block <= 1'b1; tgt_fault <= 2'h1; e0 = n_evt; step(1);
        check("blocked", 2, {start, blocked, trip});
        step(3);
        check("trip", 0, trip);
        check("events", 1, n_evt - e0);
        check("blk_stamp", s0 + 32'h00000007, blk_stamp);
        check("blk_fault", 1, blk_fault);
        check("blk_value", 16'h0070, blk_value);
        tgt_block <= 1'b0; tgt_meas <= 16'h0000; step(3);
        // Under stage picks below, holds to 103 percent
        under_stage <= 1'b1; tgt_meas <= 16'h0050; step(2);
        check("start", 1, start);
        tgt_meas <= 16'h0066; step(2);
        check("start", 1, start);
        tgt_meas <= 16'h0068; step(2);
        check("start", 0, start);
        under_stage <= 1'b0; tgt_meas <= 16'h0000; step(3);
        // Fixed mode ignores magnitude and curve series
        curve_series <= series_ieee;
        measure(16'h0065, na);
        measure(16'h02BC, nb);
        check("fixed_steps", 4, na);
        check("fixed_steps", 4, nb);
        // Inverse mode held by the minimum delay
        delay_type <= inverse_time_mode; curve_series <= series_iec; fixed_delay <= 19'h00003;
        tgt_meas <= 16'h02BC; step(4);
        check("trip", 0, trip);
        step(4);
        check("trip", 1, trip);
        tgt_meas <= 16'h0000; fixed_delay <= 19'h00000; step(3);
        // Larger excess trips sooner; the second series is faster
        measure(16'h0190, na);
        measure(16'h00A4, nb);
        curve_series <= series_ieee;
        measure(16'h0190, nc);
        check("slower", 1, nb > na);
        check("series", 1, nc < na);
        check("inv_trip", 1, na < 40);
        results();
    end
endmodule : protection_stage_pickup_timer_tb
`default_nettype wire
